// file: rtl/gbi_pkg.sv
/*
 * Shared constants and types for the graphics external bus interface: the strap and
 * test-mode encodings, the clock phase, pin widths and the master bus cycle states.
 * Assumes one clock (ref_clk) at twice the internal cycle rate and a synchronous,
 * active-high reset.
 */
// Summary of operation
// - address lines input, driven only as master
// - upper byte enable input, low as master
// - strap on upper byte enable picks sync
// - strobes input, driven as master
// - strobes and memory/io latched as test mode
// - memory/io input, driven high as master
// - slave access needs chip select
// - master enable high while owning bus
// - slave enable high during slave cycle
// - master cycles end on sampled ready
// - hold request held while units need bus
// - arbiter answers request with acknowledge
// - interrupt is OR of two sources
// - control register access clears interrupt
// - reset synchronized, all units to initial state
// - reset leading edge forces first phase
// - internal cycle is two input periods
`default_nettype none
package gbi_pkg;
   localparam int          ADDR_W        = 22;
   localparam int          DATA_W        = 16;
   localparam int          MODE_W        = 3;
   localparam logic        PHASE_FIRST   = 1'h0;
   localparam logic        PHASE_SECOND  = 1'h1;
   localparam logic        STRAP_RST     = 1'h0;
   localparam logic [2:0]  MODE_RST      = 3'h0;
   localparam logic [2:0]  MODE_NORMAL   = 3'h7;
   localparam logic [1:0]  SLV_WAIT      = 2'h1;
   localparam logic [3:0]  HOST_WAIT     = 4'h2;

   typedef enum logic [3:0] {
      MST_IDLE = 4'b0001,
      MST_WAIT = 4'b0010,
      MST_CYC  = 4'b0100,
      MST_DONE = 4'b1000
   } gbi_mst_t;
endpackage : gbi_pkg
`default_nettype wire

// file: rtl/gbi_if.sv
/*
 * Interface carrying the external bus pins between the device end and the outside
 * master / arbiter end. Each two-way pin is carried as output and enable from each
 * side; the resolved wire level is formed here so neither end needs an inout.
 */
`default_nettype none
interface gbi_if;
   import gbi_pkg::*;
   logic [ADDR_W-1:0] dev_addr_o, host_addr_o, addr;
   logic              dev_addr_oe, host_addr_oe;
   logic [DATA_W-1:0] dev_data_o, host_data_o, data;
   logic              dev_data_oe, host_data_oe;
   logic              dev_ube_o, host_ube_o, ube;
   logic              dev_rd_o, host_rd_o, rd_n;
   logic              dev_wr_o, host_wr_o, wr_n;
   logic              dev_mio_o, host_mio_o, mio;
   logic              dev_ctl_oe, host_ctl_oe;
   logic              chip_select;
   logic              ready;
   logic              hold_request;
   logic              hold_acknowledge;
   logic              master_path_enable;
   logic              slave_path_enable;
   logic              interrupt_out;
   logic              reset_pin;

   // idle levels model pull-ups on the control pins of a floating bus; address and data idle at zero
   assign addr = dev_addr_oe ? dev_addr_o : (host_addr_oe ? host_addr_o : '0);
   assign data = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : '0);
   assign ube  = dev_ctl_oe ? dev_ube_o : (host_ctl_oe ? host_ube_o : 1'b1);
   assign rd_n = dev_ctl_oe ? dev_rd_o  : (host_ctl_oe ? host_rd_o  : 1'b1);
   assign wr_n = dev_ctl_oe ? dev_wr_o  : (host_ctl_oe ? host_wr_o  : 1'b1);
   assign mio  = dev_ctl_oe ? dev_mio_o : (host_ctl_oe ? host_mio_o : 1'b1);

   modport device (
      input  addr, data, ube, rd_n, wr_n, mio, chip_select, ready, hold_acknowledge,
      input  reset_pin,
      output dev_addr_o, dev_addr_oe, dev_data_o, dev_data_oe, dev_ube_o, dev_rd_o,
      output dev_wr_o, dev_mio_o, dev_ctl_oe, hold_request, master_path_enable,
      output slave_path_enable, interrupt_out
   );
   modport host (
      input  addr, data, ube, rd_n, wr_n, mio, hold_request, master_path_enable,
      input  slave_path_enable, interrupt_out,
      output host_addr_o, host_addr_oe, host_data_o, host_data_oe, host_ube_o,
      output host_rd_o, host_wr_o, host_mio_o, host_ctl_oe, chip_select, ready,
      output hold_acknowledge, reset_pin
   );
endinterface : gbi_if
`default_nettype wire

// file: rtl/gbi_sync.sv
/*
 * Two-flop synchroniser with bypass. Used for inputs whose timing mode is picked by
 * a strap: in synchronous mode the raw level is used after one register.
 * Assumes one clock; the first flop feeds only the second.
 */
`default_nettype none
module gbi_sync (
   input  wire logic ref_clk,
   input  wire logic clk_en,
   input  wire logic sys_rst,
   input  wire logic rst_val,
   input  wire logic async_mode,
   input  wire logic din,
   output logic      dout
);
   logic meta_ff;
   logic sync_ff;
   logic direct_ff;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         meta_ff   <= rst_val;
         sync_ff   <= rst_val;
         direct_ff <= rst_val;
      end else if (clk_en) begin
         meta_ff   <= din;
         sync_ff   <= meta_ff;
         direct_ff <= din;
      end
   end

   assign dout = async_mode ? sync_ff : direct_ff;
endmodule : gbi_sync
`default_nettype wire

// file: rtl/gbi_device.sv
/*
 * Device end of the graphics external bus interface: slave pin roles, master bus
 * ownership through hold request/acknowledge, path enables, reset straps, merged
 * interrupt and the two-phase internal clock. Assumes the host end drives the other
 * side of gbi_if and that ref_clk runs at twice the internal cycle rate.
 */
`default_nettype none
module gbi_device (
   input  wire logic                    ref_clk,
   input  wire logic                    clk_en,
   input  wire logic                    sys_rst,
   gbi_if.device                        bus,
   input  wire logic                    gp_need_bus,
   input  wire logic                    dp_need_bus,
   input  wire logic [gbi_pkg::ADDR_W-1:0] mst_addr,
   input  wire logic [gbi_pkg::DATA_W-1:0] mst_wdata,
   input  wire logic                    mst_write,
   input  wire logic                    mst_start,
   output logic                         mst_done_ff,
   output logic [gbi_pkg::DATA_W-1:0]   mst_rdata_ff,
   input  wire logic                    gp_irq,
   input  wire logic                    dp_irq,
   input  wire logic                    ctl_reg_access,
   input  wire logic [gbi_pkg::DATA_W-1:0] slv_rdata,
   output logic                         slv_access_ff,
   output logic                         slv_write_ff,
   output logic [gbi_pkg::ADDR_W-1:0]   slv_addr_ff,
   output logic [gbi_pkg::DATA_W-1:0]   slv_wdata_ff,
   output logic                         sync_strap_ff,
   output logic [gbi_pkg::MODE_W-1:0]   test_mode_ff,
   output logic                         phase_ff,
   output logic                         core_rst_ff
);
   import gbi_pkg::*;

   logic        rst_meta_ff, rst_sync_ff;
   logic        hold_acknowledge_s, rd_s, wr_s;
   logic        irq_ff, hold_request_ff, men_ff, sen_ff, own_ff;
   logic [1:0]  slv_cnt_ff;
   gbi_mst_t    mst_ff, nxt_mst;
   logic        rst_fall;
   logic        need_bus;
   logic        slv_req;
   logic        internal_edge;
   logic        nxt_hold_request, grant_ok, irq_set, core_hold;
   logic        mst_end, slv_start, slv_end;
   logic        async_mode;
   logic [2:0]  sync_in, sync_out;

   // reset pin through two flops; first flop feeds only the second
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= 1'b1;
      end else if (clk_en) begin
         rst_meta_ff <= bus.reset_pin;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (sys_rst) core_rst_ff <= 1'b1;
      else if (clk_en) core_rst_ff <= rst_sync_ff;
   end
   assign rst_fall = core_rst_ff & ~rst_sync_ff;

   // straps taken on the trailing edge of reset
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sync_strap_ff <= STRAP_RST;
         test_mode_ff  <= MODE_RST;
      end else if (clk_en && rst_fall) begin
         sync_strap_ff <= bus.ube;
         test_mode_ff  <= {bus.rd_n, bus.wr_n, bus.mio};
      end
   end

   // phase forced to first while reset stands; two ref_clk periods per cycle
   always_ff @(posedge ref_clk) begin
      if (sys_rst) phase_ff <= PHASE_FIRST;
      else if (clk_en) phase_ff <= rst_sync_ff ? PHASE_FIRST : ~phase_ff;
   end
   assign internal_edge = (phase_ff == PHASE_SECOND);

   // the strap picks one register or two flops for each of the three timed inputs;
   // bit 2 is the grant, bit 1 the read strobe, bit 0 the write strobe
   assign async_mode = ~sync_strap_ff;
   assign sync_in    = {bus.hold_acknowledge, ~bus.rd_n, ~bus.wr_n};
   for (genvar g = 0; g < 3; g++) begin : g_pin_sync
      gbi_sync u_gbi_sync (
         .ref_clk    (ref_clk),
         .clk_en     (clk_en),
         .sys_rst    (sys_rst),
         .rst_val    (1'b0),
         .async_mode (async_mode),
         .din        (sync_in[g]),
         .dout       (sync_out[g])
      );
   end
   assign hold_acknowledge_s = sync_out[2];
   assign rd_s   = sync_out[1];
   assign wr_s   = sync_out[0];

   assign need_bus = gp_need_bus | dp_need_bus;
   assign slv_req  = bus.chip_select & (rd_s | wr_s) & ~own_ff;

   // master bus cycle sequencer
   always_comb begin
      nxt_mst = mst_ff;
      unique case (mst_ff)
         MST_IDLE: if (mst_start && own_ff) nxt_mst = MST_WAIT;
         MST_WAIT: if (internal_edge) nxt_mst = MST_CYC;
         MST_CYC:  if (internal_edge && bus.ready) nxt_mst = MST_DONE;
         MST_DONE: nxt_mst = MST_IDLE;
         default:  nxt_mst = MST_IDLE;
      endcase
   end

   // decoded events of the sequencer, the grant and the slave handshake
   assign core_hold = sys_rst | rst_sync_ff;
   assign nxt_hold_request  = need_bus | (mst_ff != MST_IDLE);
   assign grant_ok  = nxt_hold_request & hold_request_ff & hold_acknowledge_s;
   assign mst_end   = (mst_ff == MST_CYC) && (nxt_mst == MST_DONE);
   assign slv_start = slv_req & ~sen_ff;
   assign slv_end   = sen_ff & ~(rd_s | wr_s);
   assign irq_set   = gp_irq | dp_irq;

   // ownership falls in the same cycle as the request, so the pins are
   // never driven after the arbiter may have taken the bus back
   always_ff @(posedge ref_clk) begin
      if (core_hold) begin
         mst_ff  <= MST_IDLE;
         hold_request_ff <= 1'b0;
         own_ff  <= 1'b0;
         men_ff  <= 1'b0;
      end else if (clk_en) begin
         mst_ff  <= nxt_mst;
         hold_request_ff <= nxt_hold_request;
         own_ff  <= grant_ok;
         men_ff  <= grant_ok;
      end
   end

   // a new source event beats the clearing access
   always_ff @(posedge ref_clk) begin
      if (core_hold) irq_ff <= 1'b0;
      else if (clk_en) irq_ff <= irq_set | (irq_ff & ~ctl_reg_access);
   end

   // result of a master cycle
   always_ff @(posedge ref_clk) begin
      if (core_hold) begin
         mst_done_ff  <= 1'b0;
         mst_rdata_ff <= '0;
      end else if (clk_en) begin
         mst_done_ff <= mst_end;
         if (mst_end && !mst_write) mst_rdata_ff <= bus.data;
      end
   end

   // slave enable rises on a selected strobe and falls when the strobes drop
   always_ff @(posedge ref_clk) begin
      if (core_hold) begin
         sen_ff        <= 1'b0;
         slv_cnt_ff    <= 2'h0;
         slv_access_ff <= 1'b0;
      end else if (clk_en) begin
         slv_access_ff <= slv_start;
         if (slv_start) begin
            sen_ff     <= 1'b1;
            slv_cnt_ff <= SLV_WAIT;
         end else if (slv_end) begin
            sen_ff <= 1'b0;
         end else if (slv_cnt_ff != 2'h0) begin
            slv_cnt_ff <= slv_cnt_ff - 2'h1;
         end
      end
   end

   // slave request handed to the memory and register side
   always_ff @(posedge ref_clk) begin
      if (core_hold) begin
         slv_write_ff <= 1'b0;
         slv_addr_ff  <= '0;
         slv_wdata_ff <= '0;
      end else if (clk_en && slv_start) begin
         slv_write_ff <= wr_s;
         slv_addr_ff  <= bus.addr;
         slv_wdata_ff <= bus.data;
      end
   end

   // pin drive: everything but data follows ownership
   always_comb begin
      bus.dev_ctl_oe  = own_ff;
      bus.dev_addr_oe = own_ff;
      bus.dev_addr_o  = mst_addr;
      bus.dev_ube_o   = 1'b0;
      bus.dev_mio_o   = 1'b1;
      bus.dev_rd_o    = !((mst_ff == MST_CYC) && !mst_write);
      bus.dev_wr_o    = !((mst_ff == MST_CYC) && mst_write);
      bus.dev_data_oe = (own_ff && mst_write && mst_ff != MST_IDLE) ||
                        (sen_ff && !slv_write_ff);
      bus.dev_data_o  = own_ff ? mst_wdata : slv_rdata;
      bus.hold_request       = hold_request_ff;
      bus.master_path_enable = men_ff;
      bus.slave_path_enable  = sen_ff;
      bus.interrupt_out      = irq_ff;
   end
endmodule : gbi_device
`default_nettype wire

// file: rtl/gbi_host.sv
/*
 * Outside end: a simple bus master and arbiter. It runs slave reads and writes into
 * the device with chip select and grants the bus on hold request. Assumes the device
 * end on the other side of gbi_if.
 */
`default_nettype none
module gbi_host (
   input  wire logic                       ref_clk,
   input  wire logic                       clk_en,
   input  wire logic                       sys_rst,
   gbi_if.host                             bus,
   input  wire logic                       req_valid,
   input  wire logic                       req_write,
   input  wire logic [gbi_pkg::ADDR_W-1:0] req_addr,
   input  wire logic [gbi_pkg::DATA_W-1:0] req_wdata,
   input  wire logic                       dev_reset,
   output logic                            req_busy_ff,
   output logic                            rsp_valid_ff,
   output logic [gbi_pkg::DATA_W-1:0]      rsp_rdata_ff
);
   import gbi_pkg::*;

   logic              hold_acknowledge_ff, act_ff, wr_ff, drive_ff;
   logic [3:0]        cnt_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [DATA_W-1:0] wdata_ff;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         hold_acknowledge_ff <= 1'b0; act_ff <= 1'b0; wr_ff <= 1'b0; drive_ff <= 1'b0;
         cnt_ff <= 4'h0; addr_ff <= '0; wdata_ff <= '0;
         req_busy_ff <= 1'b0; rsp_valid_ff <= 1'b0; rsp_rdata_ff <= '0;
      end else if (clk_en) begin
         // grant only when idle, keep it until request drops
         hold_acknowledge_ff  <= bus.hold_request & (hold_acknowledge_ff | ~act_ff);
         rsp_valid_ff <= 1'b0;
         if (!act_ff && req_valid && !bus.hold_request && !hold_acknowledge_ff) begin
            act_ff <= 1'b1; wr_ff <= req_write; addr_ff <= req_addr;
            wdata_ff <= req_wdata; cnt_ff <= HOST_WAIT; req_busy_ff <= 1'b1;
            drive_ff <= 1'b1;
         end else if (act_ff && cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
         end else if (act_ff && bus.slave_path_enable && drive_ff) begin
            drive_ff <= 1'b0;
            if (!wr_ff) rsp_rdata_ff <= bus.data;
            rsp_valid_ff <= 1'b1;
         end else if (act_ff && !drive_ff && !bus.slave_path_enable) begin
            act_ff <= 1'b0; req_busy_ff <= 1'b0;
         end
      end
   end

   always_comb begin
      bus.host_ctl_oe  = ~hold_acknowledge_ff;
      bus.host_addr_oe = act_ff;
      bus.host_addr_o  = addr_ff;
      bus.host_data_oe = act_ff & wr_ff;
      bus.host_data_o  = wdata_ff;
      bus.host_ube_o   = 1'b1;
      bus.host_rd_o    = ~(drive_ff & ~wr_ff);
      bus.host_wr_o    = ~(drive_ff & wr_ff);
      bus.host_mio_o   = 1'b1;
      bus.chip_select  = act_ff;
      bus.ready        = 1'b1;
      bus.hold_acknowledge = hold_acknowledge_ff;
      bus.reset_pin    = dev_reset;
   end
endmodule : gbi_host
`default_nettype wire

// file: test/gbi_chk.sv
/*
 * Pin checks on the gbi_if wires joining the device end and the host end.
 * Assumes it is instantiated in the bench top beside that interface, on ref_clk.
 */
`default_nettype none
module gbi_chk (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic rd_n,
   input  wire logic wr_n,
   input  wire logic chip_select,
   input  wire logic hold_request,
   input  wire logic hold_acknowledge,
   input  wire logic master_path_enable,
   input  wire logic slave_path_enable,
   input  wire logic interrupt_out,
   input  wire logic dev_addr_oe,
   input  wire logic dev_ctl_oe,
   input  wire logic dev_ube_o,
   input  wire logic dev_mio_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_addr_master_only: assert property (dev_addr_oe |-> hold_request && hold_acknowledge)
      else $error("address driven without bus grant");
   a_ctl_master_only: assert property (dev_ctl_oe |-> hold_acknowledge)
      else $error("strobes driven without bus grant");
   a_ube_low_master: assert property (dev_ctl_oe |-> !dev_ube_o)
      else $error("upper byte enable not low as master");
   a_mio_high_master: assert property (dev_ctl_oe |-> dev_mio_o)
      else $error("memory indication not high as master");
   a_men_needs_grant: assert property (
      master_path_enable |-> $past(hold_request) && $past(hold_acknowledge))
      else $error("master enable without request and grant");
   a_men_after_grant: assert property (
      $rose(hold_acknowledge) |-> ##[1:4] (master_path_enable || !hold_request))
      else $error("master enable late after grant");
   a_grant_answers: assert property (
      $rose(hold_request) |-> ##[1:40] (hold_acknowledge || !hold_request))
      else $error("hold request not answered");
   a_grant_holds: assert property (hold_request && hold_acknowledge |=> hold_acknowledge)
      else $error("grant dropped while still requested");
   a_sen_needs_cs: assert property (
      $rose(slave_path_enable) |-> chip_select && !(rd_n && wr_n))
      else $error("slave enable without select and strobe");
   a_sen_ends: assert property (
      slave_path_enable && rd_n && wr_n |-> ##[1:3] !slave_path_enable)
      else $error("slave enable stuck after strobes");
   a_paths_exclusive: assert property (!(master_path_enable && slave_path_enable))
      else $error("master and slave enables together");
   a_reset_quiet: assert property (disable iff (1'b0)
      sys_rst |=> !master_path_enable && !slave_path_enable && !interrupt_out)
      else $error("outputs active in reset");

   c_slave_write: cover property ($rose(slave_path_enable) && !wr_n);
   c_slave_read: cover property ($rose(slave_path_enable) && !rd_n);
   c_master_own: cover property ($rose(master_path_enable));
   c_irq: cover property ($rose(interrupt_out));
endmodule : gbi_chk
`default_nettype wire

// file: test/gbi_tb_top.sv
/*
 * Bench joining gbi_device and gbi_host through gbi_if, with slave, master,
 * interrupt and reset sequences. Assumes the gbi_pkg constants and a 25 MHz clock.
 */
`default_nettype none
module gbi_tb_top;
   import gbi_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic                ref_clk = 0, sys_rst = 1, dev_reset = 1, clk_en = 1;
   logic                gp_need_bus = 0, dp_need_bus = 0, mst_write = 0, mst_start = 0;
   logic                gp_irq = 0, dp_irq = 0, ctl_reg_access = 0;
   logic                req_valid = 0, req_write = 0;
   logic [ADDR_W-1:0]   mst_addr = '0, req_addr = '0, slv_addr_ff, a;
   logic [DATA_W-1:0]   mst_wdata = '0, slv_rdata = '0, req_wdata = '0, d, p;
   logic [DATA_W-1:0]   mst_rdata_ff, slv_wdata_ff, rsp_rdata_ff, m_data;
   logic [ADDR_W-1:0]   m_addr;
   logic [MODE_W-1:0]   test_mode_ff;
   logic                mst_done_ff, slv_access_ff, slv_write_ff, sync_strap_ff, phase_ff;
   logic                core_rst_ff, req_busy_ff, rsp_valid_ff;
   logic                acc_seen, sen_seen, m_ube, m_mio, m_wr, m_rd;
   int                  errors = 0, samples_checked = 0, cycles = 0, n, i;

   always #20 ref_clk = ~ref_clk;
   gbi_if u_gbi_if ();
   gbi_device u_gbi_device (.ref_clk, .clk_en, .sys_rst, .bus(u_gbi_if), .gp_need_bus,
      .dp_need_bus, .mst_addr, .mst_wdata, .mst_write, .mst_start, .mst_done_ff, .mst_rdata_ff,
      .gp_irq, .dp_irq, .ctl_reg_access, .slv_rdata, .slv_access_ff, .slv_write_ff,
      .slv_addr_ff, .slv_wdata_ff, .sync_strap_ff, .test_mode_ff, .phase_ff, .core_rst_ff);
   gbi_host u_gbi_host (.ref_clk, .clk_en, .sys_rst, .bus(u_gbi_if), .req_valid,
      .req_write, .req_addr, .req_wdata, .dev_reset, .req_busy_ff, .rsp_valid_ff, .rsp_rdata_ff);
   gbi_chk u_gbi_chk (.ref_clk, .sys_rst, .rd_n(u_gbi_if.rd_n), .wr_n(u_gbi_if.wr_n),
      .chip_select(u_gbi_if.chip_select), .hold_request(u_gbi_if.hold_request),
      .hold_acknowledge(u_gbi_if.hold_acknowledge),
      .master_path_enable(u_gbi_if.master_path_enable),
      .slave_path_enable(u_gbi_if.slave_path_enable), .interrupt_out(u_gbi_if.interrupt_out),
      .dev_addr_oe(u_gbi_if.dev_addr_oe), .dev_ctl_oe(u_gbi_if.dev_ctl_oe),
      .dev_ube_o(u_gbi_if.dev_ube_o), .dev_mio_o(u_gbi_if.dev_mio_o));

   task finish_test();
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task tick();
      @(posedge ref_clk);
      #1;
   endtask : tick

   // one slave transfer from the host end, held until the host reports busy
   task host_rw(input logic wr, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd);
      int k;
      acc_seen = 0;
      sen_seen = 0;
      req_write = wr;
      req_addr = ad;
      req_wdata = wd;
      req_valid = 1;
      for (k = 0; k < 20 && req_busy_ff !== 1'b1; k++) tick();
      req_valid = 0;
      for (k = 0; k < 40 && rsp_valid_ff !== 1'b1; k++) tick();
      chk("rsp_valid", rsp_valid_ff, 1);
      for (k = 0; k < 20 && req_busy_ff !== 1'b0; k++) tick();
   endtask : host_rw

   // bus watch: slave activity flags and the pins of the last master strobe
   always @(posedge ref_clk) begin
      if (slv_access_ff) acc_seen = 1;
      if (u_gbi_if.slave_path_enable) sen_seen = 1;
      if (u_gbi_if.dev_ctl_oe && !(u_gbi_if.rd_n && u_gbi_if.wr_n)) begin
         m_addr = u_gbi_if.addr;
         m_data = u_gbi_if.data;
         m_ube = u_gbi_if.ube;
         m_mio = u_gbi_if.mio;
         m_wr = !u_gbi_if.wr_n;
         m_rd = !u_gbi_if.rd_n;
      end
      cycles++;
      if (cycles == 4000) begin
         errors++;
         finish_test();
      end
   end

   initial begin
      repeat (10) tick();
      chk("core_rst", core_rst_ff, 1);
      chk("phase", phase_ff, PHASE_FIRST);
      sys_rst = 0;
      dev_reset = 0;
      repeat (8) tick();
      chk("sync_strap", sync_strap_ff, 1);
      chk("test_mode", test_mode_ff, MODE_NORMAL);
      chk("core_rst", core_rst_ff, 0);
      p = phase_ff;
      tick();
      chk("phase", phase_ff, !p[0]);
      p = phase_ff;
      clk_en = 0;
      repeat (3) tick();
      chk("phase_hold", phase_ff, p[0]);
      clk_en = 1;
      for (i = 0; i < 2; i++) begin
         a = i ? 22'h3fffff : 22'h000001;
         d = i ? 16'h8001 : 16'h7ffe;
         host_rw(1, a, d);
         chk("slv_access", acc_seen, 1);
         chk("sen", sen_seen, 1);
         chk("slv_write", slv_write_ff, 1);
         chk("slv_addr", slv_addr_ff, a);
         chk("slv_wdata", slv_wdata_ff, d);
         slv_rdata = ~d;
         host_rw(0, a, 16'h0000);
         chk("slv_write", slv_write_ff, 0);
         chk("rsp_rdata", rsp_rdata_ff, slv_rdata);
      end
      gp_need_bus = 1;
      for (n = 0; n < 20 && u_gbi_if.master_path_enable !== 1'b1; n++) tick();
      chk("men", u_gbi_if.master_path_enable, 1);
      chk("hold_request", u_gbi_if.hold_request, 1);
      for (i = 0; i < 2; i++) begin
         tick();
         mst_addr = 22'h2aaaa5;
         mst_wdata = 16'hc3a5;
         mst_write = (i == 0);
         mst_start = 1;
         tick();
         mst_start = 0;
         for (n = 0; n < 40 && mst_done_ff !== 1'b1; n++) tick();
         chk("mst_done", mst_done_ff, 1);
         chk(i ? "m_rd" : "m_wr", i ? m_rd : m_wr, 1);
         chk("m_addr", m_addr, 22'h2aaaa5);
         chk("m_ube", m_ube, 0);
         chk("m_mio", m_mio, 1);
         chk("m_data", m_data, i ? 16'h0000 : 16'hc3a5);
         if (i) chk("mst_rdata", mst_rdata_ff, 16'h0000);
      end
      dp_need_bus = 1;
      tick();
      gp_need_bus = 0;
      repeat (6) tick();
      chk("hold_request", u_gbi_if.hold_request, 1);
      chk("men", u_gbi_if.master_path_enable, 1);
      dp_need_bus = 0;
      for (n = 0; n < 20 && u_gbi_if.master_path_enable !== 1'b0; n++) tick();
      chk("hold_request", u_gbi_if.hold_request, 0);
      chk("men", u_gbi_if.master_path_enable, 0);
      chk("irq", u_gbi_if.interrupt_out, 0);
      for (i = 0; i < 2; i++) begin
         gp_irq = (i == 0);
         dp_irq = (i == 1);
         tick();
         gp_irq = 0;
         dp_irq = 0;
         for (n = 0; n < 10 && u_gbi_if.interrupt_out !== 1'b1; n++) tick();
         chk("irq", u_gbi_if.interrupt_out, 1);
         ctl_reg_access = 1;
         tick();
         ctl_reg_access = 0;
         repeat (3) tick();
         chk("irq", u_gbi_if.interrupt_out, 0);
      end
      dev_reset = 1;
      repeat (4) tick();
      chk("core_rst", core_rst_ff, 1);
      chk("phase", phase_ff, PHASE_FIRST);
      dev_reset = 0;
      repeat (8) tick();
      chk("core_rst", core_rst_ff, 0);
      finish_test();
   end
endmodule : gbi_tb_top
`default_nettype wire
